/* File: src/irq_enable_priority_regs.sv */
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module irq_enable_priority_regs
    import irq_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [irq_regs_pkg::NUM_EN-1:0] en_src_flag,
    input wire logic [irq_regs_pkg::NUM_PRIO-1:0] prio_src_flag,
    output logic [irq_regs_pkg::NUM_EN-1:0] en_src_req,
    output logic [irq_regs_pkg::NUM_PRIO-1:0] prio_src_req,
    output logic [irq_regs_pkg::NUM_PRIO*irq_regs_pkg::PRIO_W-1:0] prio_level,
    output logic irq
);

    // ------------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------------
    logic [REG_W-1:0] enable3_ff;
    logic [REG_W-1:0] enable4_ff;
    logic [REG_W-1:0] enable5_ff;
    logic [REG_W-1:0] prio0_ff;
    logic [REG_W-1:0] prio1_ff;
    logic [ST_W-1:0] status_ff;
    logic [ST_W-1:0] mask_ff;
    logic [ST_W-1:0] nxt_status;
    logic any_req_ff;
    logic [NUM_EN-1:0] en_bits;
    logic [NUM_PRIO*PRIO_W-1:0] prio_fields;
    logic [NUM_EN-1:0] en_prio_ok;
    logic [NUM_EN-1:0] nxt_en_req;
    logic [NUM_PRIO-1:0] nxt_prio_req;
    logic [NUM_PRIO-1:0] ones_prio;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] nxt_rdata;
    logic nxt_any_req;
    // Next values and per-word write strobes.
    logic [REG_W-1:0] nxt_enable3;
    logic [REG_W-1:0] nxt_enable4;
    logic [REG_W-1:0] nxt_enable5;
    logic [REG_W-1:0] nxt_prio0;
    logic [REG_W-1:0] nxt_prio1;
    logic [ST_W-1:0] nxt_mask;
    logic wr_en3;
    logic wr_en4;
    logic wr_en5;
    logic wr_pr0;
    logic wr_pr1;
    logic wr_st;
    logic wr_msk;

    // Writes keep only implemented bits, so unused bits stay zero.
    function automatic logic [REG_W-1:0] merge(
        input logic [31:0] wd,
        input logic [REG_W-1:0] msk
    );
        merge = wd[REG_W-1:0] & msk;
    endfunction : merge

    // Reads widen a 16-bit register onto the 32-bit bus.
    function automatic logic [31:0] widen(input logic [REG_W-1:0] v);
        widen = {16'h0000, v};
    endfunction : widen

    // Word decode shared by every write strobe; the bus carries whole
    // byte addresses, so only an exact match selects a word.
    function automatic logic hit(
        input logic [7:0] a,
        input logic [7:0] word
    );
        hit = (a == word);
    endfunction : hit

    // ------------------------------------------------------------------
    // APB decode. The slave always answers in the access phase itself.
    // ------------------------------------------------------------------
    // Writes act at the access-phase edge, reads are latched in setup.
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    // Per-word write strobes, each true only at the access-phase edge.
    assign wr_en3 = wr_en & hit(paddr, ADDR_ENABLE_3);
    assign wr_en4 = wr_en & hit(paddr, ADDR_ENABLE_4);
    assign wr_en5 = wr_en & hit(paddr, ADDR_ENABLE_5);
    assign wr_pr0 = wr_en & hit(paddr, ADDR_PRIO_0);
    assign wr_pr1 = wr_en & hit(paddr, ADDR_PRIO_1);
    assign wr_st = wr_en & hit(paddr, ADDR_IRQ_STATUS);
    assign wr_msk = wr_en & hit(paddr, ADDR_IRQ_MASK);

    // Read mux and address check; an unmapped word reads as zero.
    always_comb begin
        addr_ok = 1'b1;
        nxt_rdata = 32'h0000_0000;
        case (paddr)
            ADDR_ENABLE_3: nxt_rdata = widen(enable3_ff);
            ADDR_ENABLE_4: nxt_rdata = widen(enable4_ff);
            ADDR_ENABLE_5: nxt_rdata = widen(enable5_ff);
            ADDR_PRIO_0: nxt_rdata = widen(prio0_ff);
            ADDR_PRIO_1: nxt_rdata = widen(prio1_ff);
            ADDR_IRQ_STATUS: nxt_rdata = {30'h0, status_ff};
            ADDR_IRQ_MASK: nxt_rdata = {30'h0, mask_ff};
            ADDR_REQ_VIEW: nxt_rdata = {31'h0, any_req_ff};
            default: addr_ok = 1'b0;
        endcase
    end

    // Read data is captured in setup so it is steady in the access
    // phase and still comes straight from a flip-flop.
    // A read of the status word therefore shows it as it stood at setup.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= nxt_rdata;
        end
    end

    // Ready and error are registered in setup; the access phase then
    // completes in its first cycle (no wait states).
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
        end
    end

    // ------------------------------------------------------------------
    // Enable registers.
    // ------------------------------------------------------------------
    // A write replaces a whole word, implemented bits only; any other
    // cycle the word holds its value.
    always_comb begin
        nxt_enable3 = enable3_ff;
        nxt_enable4 = enable4_ff;
        nxt_enable5 = enable5_ff;
        if (wr_en3) begin
            nxt_enable3 = merge(pwdata, MASK_ENABLE_3);
        end
        if (wr_en4) begin
            nxt_enable4 = merge(pwdata, MASK_ENABLE_4);
        end
        if (wr_en5) begin
            nxt_enable5 = merge(pwdata, MASK_ENABLE_5);
        end
    end

    // Enable words load their next values on every edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable3_ff <= RST_ENABLE;
            enable4_ff <= RST_ENABLE;
            enable5_ff <= RST_ENABLE;
        end else begin
            enable3_ff <= nxt_enable3;
            enable4_ff <= nxt_enable4;
            enable5_ff <= nxt_enable5;
        end
    end

    // ------------------------------------------------------------------
    // Priority registers; fields reset to level 4.
    // ------------------------------------------------------------------
    // Same write path as the enables; unused bits of each word and the
    // low nibble of the second word stay zero.
    always_comb begin
        nxt_prio0 = prio0_ff;
        nxt_prio1 = prio1_ff;
        if (wr_pr0) begin
            nxt_prio0 = merge(pwdata, MASK_PRIO_0);
        end
        if (wr_pr1) begin
            nxt_prio1 = merge(pwdata, MASK_PRIO_1);
        end
    end

    // Priority words load their next values on every edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio0_ff <= RST_PRIO_0;
            prio1_ff <= RST_PRIO_1;
        end else begin
            prio0_ff <= nxt_prio0;
            prio1_ff <= nxt_prio1;
        end
    end

    // ------------------------------------------------------------------
    // Source gating.
    // ------------------------------------------------------------------
    // Enable bits packed in order: enable 3 (14,6,5,2,1), enable 4
    // (13,8,3,2,1), enable 5 (13 down to 1).
    // Bit 0 of every enable word is unused and never reaches a gate.
    assign en_bits = {enable3_ff[14], enable3_ff[6], enable3_ff[5],
                      enable3_ff[2], enable3_ff[1],
                      enable4_ff[13], enable4_ff[8], enable4_ff[3],
                      enable4_ff[2], enable4_ff[1],
                      enable5_ff[13:1]};

    // Priority fields packed: timer1, compare1, capture1, pin0,
    // timer2, compare2, capture2. Codes pass through as levels.
    // Arbitration reads them as levels 1 to 7; code 000 never requests.
    assign prio_fields = {
        prio0_ff[FLD_HI +: PRIO_W], prio0_ff[FLD_MH +: PRIO_W],
        prio0_ff[FLD_ML +: PRIO_W], prio0_ff[FLD_LO +: PRIO_W],
        prio1_ff[FLD_HI +: PRIO_W], prio1_ff[FLD_MH +: PRIO_W],
        prio1_ff[FLD_ML +: PRIO_W]};

    // Their priority fields lie outside this slice, so they count as
    // nonzero here; the arbiter applies its own field downstream.
    assign en_prio_ok = {NUM_EN{1'b1}};
    assign ones_prio = {NUM_PRIO{1'b1}};

    // Each enable-register source gated by its enable bit. The gate is
    // the same cell as for the priority sources, so both paths share
    // one definition of what lets a request through.
    for (genvar i = 0; i < NUM_EN; i++) begin : g_en
        irq_gate u_gate (
            .flag(en_src_flag[i]),
            .enable(en_bits[i]),
            .prio(en_prio_ok[i] ? ~PRIO_OFF : PRIO_OFF),
            .req(nxt_en_req[i])
        );
    end

    // Priority-register sources: enables live elsewhere, so only the
    // field can block them; code 000 turns the source off. Its level
    // still shows on the level output, which arbitration then ignores.
    for (genvar j = 0; j < NUM_PRIO; j++) begin : g_pr
        irq_gate u_gate (
            .flag(prio_src_flag[j]),
            .enable(ones_prio[j]),
            .prio(prio_fields[j*PRIO_W +: PRIO_W]),
            .req(nxt_prio_req[j])
        );
    end

    // Any passed request, used for the rise event and the request view.
    assign nxt_any_req = (|nxt_en_req) | (|nxt_prio_req);

    // Registered requests keep every top output on a flip-flop, at the
    // cost of one cycle of latency toward arbitration.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_src_req <= '0;
            prio_src_req <= '0;
            prio_level <= '0;
            any_req_ff <= 1'b0;
        end else begin
            en_src_req <= nxt_en_req;
            prio_src_req <= nxt_prio_req;
            prio_level <= prio_fields;
            any_req_ff <= nxt_any_req;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, mask and output.
    // ------------------------------------------------------------------
    // Events: a write to an unmapped address, and a rise of any request.
    // Write-one-to-clear; a new event in the same cycle wins, so an
    // event is never lost to a clear that races it.
    always_comb begin
        nxt_status = status_ff;
        if (wr_st) begin
            nxt_status = status_ff & ~pwdata[ST_W-1:0];
        end
        if (wr_en && !addr_ok) begin
            nxt_status[ST_WR_ERR] = 1'b1;
        end
        if (nxt_any_req && !any_req_ff) begin
            nxt_status[ST_REQ_RISE] = 1'b1;
        end
    end

    // Sticky status bits; they only fall on a write of ones.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // The mask takes a write of its word; other cycles it holds.
    always_comb begin
        nxt_mask = mask_ff;
        if (wr_msk) begin
            nxt_mask = pwdata[ST_W-1:0];
        end
    end

    // Mask word loads its next value on every edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= '0;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    // The line is built from the next status and next mask, so it
    // follows a mask write on the same edge rather than one later; the
    // price is a longer path from the bus into this flip-flop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(nxt_status & nxt_mask);
        end
    end

endmodule : irq_enable_priority_regs

`default_nettype wire

/* File: src/irq_regs_pkg.sv */
package irq_regs_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the APB word grid).
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE_3 = 8'h00;
    localparam logic [7:0] ADDR_ENABLE_4 = 8'h04;
    localparam logic [7:0] ADDR_ENABLE_5 = 8'h08;
    localparam logic [7:0] ADDR_PRIO_0 = 8'h0C;
    localparam logic [7:0] ADDR_PRIO_1 = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_REQ_VIEW = 8'h1C;

    // ------------------------------------------------------------------
    // Widths and implemented-bit masks.
    // ------------------------------------------------------------------
    localparam int REG_W = 16;
    localparam int PRIO_W = 3;
    localparam int NUM_PRIO = 7;
    localparam int NUM_EN = 23;
    localparam int NUM_SRC = NUM_EN + NUM_PRIO;
    localparam logic [15:0] MASK_ENABLE_3 = 16'h4066;
    localparam logic [15:0] MASK_ENABLE_4 = 16'h210E;
    localparam logic [15:0] MASK_ENABLE_5 = 16'h3FFE;
    localparam logic [15:0] MASK_PRIO_0 = 16'h7777;
    localparam logic [15:0] MASK_PRIO_1 = 16'h7770;

    // Reset values: enables clear, every priority field at binary 100.
    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [15:0] RST_PRIO_0 = 16'h4444;
    localparam logic [15:0] RST_PRIO_1 = 16'h4440;
    localparam logic [2:0] PRIO_OFF = 3'h0;

    // Field low bit positions in the priority registers.
    localparam int FLD_HI = 12;
    localparam int FLD_MH = 8;
    localparam int FLD_ML = 4;
    localparam int FLD_LO = 0;

    // Interrupt status bit positions.
    localparam int ST_WR_ERR = 0;
    localparam int ST_REQ_RISE = 1;
    localparam int ST_W = 2;

endpackage : irq_regs_pkg

/* File: src/irq_gate.sv */
`timescale 1ns/1ps
`default_nettype none

module irq_gate
    import irq_regs_pkg::*;
(
    input wire logic flag,
    input wire logic enable,
    input wire logic [irq_regs_pkg::PRIO_W-1:0] prio,
    output logic req
);
    // A zero priority blocks the source whatever its enable says.
    assign req = flag & enable & (prio != PRIO_OFF);
endmodule : irq_gate

`default_nettype wire

/* File: testbench/src_flag_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Peripheral request lines seen by the block.
// ----------------------------------------------------------------------
module src_flag_model (
    input wire logic clk,
    input wire logic routed,
    input wire logic [29:0] val,
    output logic [22:0] en_flag,
    output logic [6:0] prio_flag
);
    // Pin sources within the packed flags: pins 4 and 3 among the
    // enable flags, pin 0 among the priority flags.
    localparam logic [29:0] PIN_BITS = 30'h1800_0008;

    // Flags move just after an edge, as a real peripheral would. A pin
    // source drives nothing until software has routed it to a pin.
    always_ff @(posedge clk) begin
        {en_flag, prio_flag} <= routed ? val : (val & ~PIN_BITS);
    end
endmodule : src_flag_model

`default_nettype wire

/* File: testbench/irq_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module irq_regs_properties
    import irq_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [irq_regs_pkg::NUM_EN-1:0] en_src_flag,
    input wire logic [irq_regs_pkg::NUM_PRIO-1:0] prio_src_flag,
    input wire logic [irq_regs_pkg::NUM_EN-1:0] en_src_req,
    input wire logic [irq_regs_pkg::NUM_PRIO-1:0] prio_src_req,
    input wire logic [irq_regs_pkg::NUM_PRIO*irq_regs_pkg::PRIO_W-1:0] prio_level
);
    // Implemented bits of a word; words outside the five pass whole.
    function automatic logic [15:0] impl(input logic [7:0] a);
        case (a)
            ADDR_ENABLE_3: return 16'h4066;
            ADDR_ENABLE_4: return 16'h210E;
            ADDR_ENABLE_5: return 16'h3FFE;
            ADDR_PRIO_0: return 16'h7777;
            ADDR_PRIO_1: return 16'h7770;
            default: return 16'hFFFF;
        endcase
    endfunction : impl

    // One bit per priority field that is not zero.
    function automatic logic [6:0] live(input logic [20:0] l);
        for (int i = 0; i < 7; i++) live[i] = l[3*i +: 3] != 3'h0;
    endfunction : live

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_zero_wait;
        psel && penable |-> pready ##1 !pready;
    endproperty
    a_zero_wait: assert property (p_zero_wait)
        else $error("ready is not a one-cycle answer");
    property p_ready_cause;
        pready |-> psel && penable;
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready outside an access phase");
    property p_upper_zero;
        pready && !pwrite |-> prdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read half not zero");
    property p_unimpl_zero;
        pready && !pwrite |-> (prdata[15:0] & ~impl(paddr)) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bit reads one");
    property p_bad_addr;
        pready && paddr > 8'h1C |-> pslverr && (pwrite || prdata == 0);
    endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("unmapped word not refused");
    property p_good_addr;
        pready && paddr <= 8'h1C && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_good_addr: assert property (p_good_addr)
        else $error("mapped word refused");
    property p_en_flag;
        en_src_req != '0 |-> (en_src_req & ~$past(en_src_flag)) == '0;
    endproperty
    a_en_flag: assert property (p_en_flag)
        else $error("enable request without flag");
    property p_prio_flag;
        prio_src_req != '0 |-> (prio_src_req & ~$past(prio_src_flag)) == '0;
    endproperty
    a_prio_flag: assert property (p_prio_flag)
        else $error("priority request without flag");
    property p_prio_off;
        prio_src_req != '0 |-> (prio_src_req & ~live(prio_level)) == '0;
    endproperty
    a_prio_off: assert property (p_prio_off)
        else $error("request at priority zero");
endmodule : irq_regs_properties

`default_nettype wire

/* File: testbench/irq_enable_priority_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module irq_enable_priority_regs_bench;
    import irq_regs_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, routed;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [15:0] r [5];
    logic [29:0] fval;
    logic [22:0] en_flag, en_req, en_exp;
    logic [6:0] pr_flag, pr_req, pr_exp;
    logic [20:0] lvl, lvl_exp;
    logic [31:0] exp_q [$];
    logic err_q [$];
    int err_count, n_tests;
    localparam logic [7:0] ADR [5] = '{ADDR_ENABLE_3, ADDR_ENABLE_4,
        ADDR_ENABLE_5, ADDR_PRIO_0, ADDR_PRIO_1};
    localparam logic [15:0] IMP [5] = '{16'h4066, 16'h210E, 16'h3FFE,
        16'h7777, 16'h7770};
    localparam logic [15:0] RST [5] = '{16'h0000, 16'h0000, 16'h0000,
        16'h4444, 16'h4440};

    irq_enable_priority_regs dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .en_src_flag(en_flag), .prio_src_flag(pr_flag), .en_src_req(en_req),
        .prio_src_req(pr_req), .prio_level(lvl), .irq(irq));
    src_flag_model flags_u (.clk(clk), .routed(routed), .val(fval),
        .en_flag(en_flag), .prio_flag(pr_flag));

    // 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // Mapped words are the aligned ones up to the request view.
    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= ADDR_REQ_VIEW;
    endfunction : mapped

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %0t: got %h, want %h", $time, g, e);
        end
    endtask : chk

    // One transfer; the request holds until ready is seen at an edge.
    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        err_q.push_back(!mapped(a));
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask : rd

    // Look at the interrupt line once the previous edge has landed.
    task automatic look(input logic e);
        @(posedge clk);
        #1;
        chk({31'h0, e}, {31'h0, irq});
        @(posedge clk);
    endtask : look

    task automatic results;
        if (err_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // Every completed transfer answers with its error flag; read data
    // are taken at the edge that ends the access phase.
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            chk({31'h0, err_q.pop_front()}, {31'h0, pslverr});
            if (!pwrite)
                chk(exp_q.pop_front(), prdata);
        end
    end

    // A hung handshake would otherwise stall the run forever.
    initial begin
        repeat (4000) @(posedge clk);
        err_count++;
        results();
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        routed = 1'b0;
        fval = '0;
        seed = 32'hB38656E8;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        routed <= 1'b1;
        @(posedge clk);
        foreach (ADR[i]) rd(ADR[i], {16'h0000, RST[i]});
        // First pass writes all ones, then random words and flags.
        for (int k = 0; k < 8; k++) begin
            foreach (r[i]) begin
                seed = xs(seed);
                r[i] = (k == 0) ? 16'hFFFF : seed[15:0];
                apb(ADR[i], 1'b1, {seed[31:16], r[i]});
                rd(ADR[i], {16'h0000, r[i] & IMP[i]});
            end
            seed = xs(seed);
            fval <= seed[29:0];
            en_exp = {r[0][14], r[0][6:5], r[0][2:1], r[1][13], r[1][8],
                r[1][3:1], r[2][13:1]} & seed[29:7];
            lvl_exp = {r[3][14:12], r[3][10:8], r[3][6:4], r[3][2:0],
                r[4][14:12], r[4][10:8], r[4][6:4]};
            for (int j = 0; j < 7; j++)
                pr_exp[j] = seed[j] && lvl_exp[3*j +: 3] != 3'h0;
            repeat (3) @(posedge clk);
            #1;
            chk({9'h0, en_exp}, {9'h0, en_req});
            chk({25'h0, pr_exp}, {25'h0, pr_req});
            chk({11'h0, lvl_exp}, {11'h0, lvl});
            @(posedge clk);
        end
        // A refused write sets a sticky status bit behind a mask.
        apb(ADDR_IRQ_MASK, 1'b1, 32'h0);
        apb(ADDR_IRQ_STATUS, 1'b1, 32'h3);
        rd(8'h40, 32'h0);
        apb(8'h40, 1'b1, 32'hFFFF);
        rd(ADDR_IRQ_STATUS, 32'h1);
        look(1'b0);
        apb(ADDR_IRQ_MASK, 1'b1, 32'h1);
        look(1'b1);
        apb(ADDR_IRQ_STATUS, 1'b1, 32'h1);
        look(1'b0);
        rd(ADDR_IRQ_STATUS, 32'h0);
        // A zero field silences its source whatever its flag; a request
        // that newly passes raises the rise event behind its mask bit.
        fval <= '0;
        apb(ADDR_PRIO_0, 1'b1, 32'h0);
        apb(ADDR_PRIO_1, 1'b1, 32'hFFFF);
        apb(ADDR_IRQ_STATUS, 1'b1, 32'h3);
        rd(ADDR_REQ_VIEW, 32'h0);
        fval <= 30'h7F;
        repeat (3) @(posedge clk);
        #1;
        chk(32'h7, {25'h0, pr_req});
        chk(32'h1FF, {11'h0, lvl});
        @(posedge clk);
        rd(ADDR_REQ_VIEW, 32'h1);
        rd(ADDR_IRQ_STATUS, 32'h2);
        apb(ADDR_IRQ_MASK, 1'b1, 32'h2);
        look(1'b1);
        results();
    end
endmodule : irq_enable_priority_regs_bench

bind irq_enable_priority_regs irq_regs_properties props_u (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .en_src_flag(en_src_flag), .prio_src_flag(prio_src_flag),
    .en_src_req(en_src_req), .prio_src_req(prio_src_req),
    .prio_level(prio_level));

`default_nettype wire
